// *** hdl/parallel_ports.sv ***
// three parallel ports with pull-up control and 38 kHz carrier steering
// assumes cpu strobes are synchronous to CLK; pins arrive asynchronously
`timescale 1ns/1ps
module parallel_ports (
  input wire logic CLK,
  input wire logic RST_N,
  input wire port_pkg::sfr_req_t SFR_REQ,
  output logic [7:0] SFR_RDATA,
  output logic SFR_RVALID,
  input wire logic CARRIER_GLOBAL_ENABLE,
  input wire logic [7:0] PERIPH_OWN_ZERO,
  input wire logic [7:0] PERIPH_OWN_ONE,
  input wire logic [7:0] PERIPH_OWN_TWO,
  input wire logic [7:0] PERIPH_OUT_ZERO,
  input wire logic [7:0] PERIPH_OUT_ONE,
  input wire logic [7:0] PERIPH_OUT_TWO,
  input wire logic [7:0] PIN_IN_ZERO,
  input wire logic [7:0] PIN_IN_ONE,
  input wire logic [7:0] PIN_IN_TWO,
  output logic [7:0] PIN_OUT_ZERO,
  output logic [7:0] PIN_OE_ZERO,
  output logic [7:0] PIN_OUT_ONE,
  output logic [7:0] PIN_OE_ONE,
  output logic [7:0] PIN_OUT_TWO,
  output logic [7:0] PIN_OE_TWO,
  output logic [7:0] PULLUP_ON_ZERO,
  output logic [7:0] PULLUP_ON_ONE,
  output logic [7:0] PULLUP_ON_TWO,
  output logic [7:0] PIN_SAMPLED_ZERO
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_a_q, rst_b_q;
  logic rst_n;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_a_q <= 1'b0;
      rst_b_q <= 1'b0;
    end else begin
      rst_a_q <= 1'b1;
      rst_b_q <= rst_a_q;
    end
  end
  assign rst_n = rst_b_q;

  // ----------------------------------------------------------------
  // pin input sampling: three stages, change taken when 2nd and 3rd agree
  // ----------------------------------------------------------------
  logic [23:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_lvl_q;
  wire [23:0] pin_raw = {PIN_IN_TWO, PIN_IN_ONE, PIN_IN_ZERO};
  wire [23:0] pin_agree = ~(pin_s2_q ^ pin_s3_q);

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= '1;
      pin_s2_q <= '1;
      pin_s3_q <= '1;
      pin_lvl_q <= '1;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_lvl_q <= (pin_agree & pin_s3_q) | (~pin_agree & pin_lvl_q);
    end
  end

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  function automatic logic hit(input port_pkg::sfr_req_t r, input logic [7:0] a);
    hit = (r.addr == a);
  endfunction

  wire wr = SFR_REQ.wr;
  wire wr_p0 = wr && hit(SFR_REQ, port_pkg::PORT_ZERO_LATCH_ADDR);
  wire wr_p1 = wr && hit(SFR_REQ, port_pkg::PORT_ONE_LATCH_ADDR);
  wire wr_p2 = wr && hit(SFR_REQ, port_pkg::PORT_TWO_LATCH_ADDR);
  wire wr_sel = wr && hit(SFR_REQ, port_pkg::CARRIER_PIN_SELECT_ADDR);
  wire wr_pd0 = wr && hit(SFR_REQ, port_pkg::PULLUP_DISABLE_ZERO_ADDR);
  wire wr_pd1 = wr && hit(SFR_REQ, port_pkg::PULLUP_DISABLE_ONE_ADDR);
  wire wr_pd2 = wr && hit(SFR_REQ, port_pkg::PULLUP_DISABLE_TWO_ADDR);

  // ----------------------------------------------------------------
  // configuration and latch registers
  // ----------------------------------------------------------------
  logic [7:0] latch0_q, latch1_q, latch2_q;
  logic [7:0] carrier_select_bits_q;
  logic [7:0] pd0_q, pd1_q, pd2_q;

  // latches load straight from the data bus on a write strobe
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      latch0_q <= port_pkg::LATCH_RESET;
      latch1_q <= port_pkg::LATCH_RESET;
      latch2_q <= port_pkg::LATCH_RESET;
    end else begin
      if (wr_p0) latch0_q <= SFR_REQ.wdata;
      if (wr_p1) latch1_q <= SFR_REQ.wdata;
      if (wr_p2) latch2_q <= SFR_REQ.wdata;
    end
  end

  // pull-up disables and carrier select clear at reset, so pull-ups start on
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      carrier_select_bits_q <= port_pkg::CONFIG_RESET;
      pd0_q <= port_pkg::CONFIG_RESET;
      pd1_q <= port_pkg::CONFIG_RESET;
      pd2_q <= port_pkg::CONFIG_RESET;
    end else begin
      if (wr_sel) carrier_select_bits_q <= SFR_REQ.wdata;
      if (wr_pd0) pd0_q <= SFR_REQ.wdata;
      if (wr_pd1) pd1_q <= SFR_REQ.wdata;
      // reserved bits are stored and read back but steer nothing
      if (wr_pd2) pd2_q <= SFR_REQ.wdata;
    end
  end

  // ----------------------------------------------------------------
  // carrier generation and per-pin steering
  // ----------------------------------------------------------------
  logic wave;

  carrier_gen u_carrier (
    .clk(CLK),
    .rst_n(rst_n),
    .wave(wave)
  );

  // global enable comes from the general configuration register outside
  logic gen_s1_q, gen_s2_q;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      gen_s1_q <= 1'b0;
      gen_s2_q <= 1'b0;
    end else begin
      gen_s1_q <= CARRIER_GLOBAL_ENABLE;
      gen_s2_q <= gen_s1_q;
    end
  end
  // two-cycle lag only; the enable is cpu-written on CLK, two stages keep it tidy
  wire carrier_on = gen_s2_q;

  // select bit mapping onto the port pins
  wire [7:0] sel = carrier_select_bits_q;
  wire [7:0] mod0 = {sel[2], 1'b0, sel[1], 1'b0, sel[0], sel[3], 2'b00};
  wire [7:0] mod1 = {1'b0, sel[7], sel[6], sel[5], 2'b00, sel[4], 1'b0};
  wire [7:0] cw = {8{carrier_on & wave}};

  // level the pin would carry from the latch, carrier folded in on ports 0 and 1 only
  wire [7:0] lvl0 = latch0_q ^ (mod0 & cw);
  wire [7:0] lvl1 = latch1_q ^ (mod1 & cw);
  wire [7:0] lvl2 = latch2_q;

  // peripheral ownership overrides the port latch
  wire [7:0] src0 = (PERIPH_OWN_ZERO & PERIPH_OUT_ZERO) | (~PERIPH_OWN_ZERO & lvl0);
  wire [7:0] src1 = (PERIPH_OWN_ONE & PERIPH_OUT_ONE) | (~PERIPH_OWN_ONE & lvl1);
  wire [7:0] src2 = (PERIPH_OWN_TWO & PERIPH_OUT_TWO) | (~PERIPH_OWN_TWO & lvl2);

  // pull-up enables: port 2 only has three pins plus the reset pin
  wire [7:0] pu0 = ~pd0_q;
  wire [7:0] pu1 = ~pd1_q;
  wire [7:0] pu2 = ~pd2_q & port_pkg::PULLUP_TWO_MASK;

  // low is always driven; high is left to the pull-up, or floats when it is
  // off, so a disabled pull-up never actively drives the pin high
  wire [7:0] oe0 = ~src0;
  wire [7:0] oe1 = ~src1;
  wire [7:0] oe2 = ~src2 & port_pkg::PULLUP_TWO_MASK;

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      PIN_OUT_ZERO <= '0;
      PIN_OUT_ONE <= '0;
      PIN_OUT_TWO <= '0;
      PIN_OE_ZERO <= '0;
      PIN_OE_ONE <= '0;
      PIN_OE_TWO <= '0;
      PULLUP_ON_ZERO <= '1;
      PULLUP_ON_ONE <= '1;
      PULLUP_ON_TWO <= port_pkg::PULLUP_TWO_MASK;
    end else begin
      PIN_OUT_ZERO <= '0;
      PIN_OUT_ONE <= '0;
      PIN_OUT_TWO <= '0;
      PIN_OE_ZERO <= oe0;
      PIN_OE_ONE <= oe1;
      PIN_OE_TWO <= oe2;
      PULLUP_ON_ZERO <= pu0;
      PULLUP_ON_ONE <= pu1;
      PULLUP_ON_TWO <= pu2;
    end
  end

  // ----------------------------------------------------------------
  // read path: latch for read-modify-write, pins otherwise
  // ----------------------------------------------------------------
  wire rd = SFR_REQ.rd;
  wire use_latch = SFR_REQ.rmw;
  wire [7:0] rd_p0 = use_latch ? latch0_q : pin_lvl_q[7:0];
  wire [7:0] rd_p1 = use_latch ? latch1_q : pin_lvl_q[15:8];
  wire [7:0] rd_p2 = use_latch ? latch2_q : pin_lvl_q[23:16];

  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = port_pkg::READ_ZERO;
    case (SFR_REQ.addr)
      port_pkg::PORT_ZERO_LATCH_ADDR: rd_mux = rd_p0;
      port_pkg::PORT_ONE_LATCH_ADDR: rd_mux = rd_p1;
      port_pkg::PORT_TWO_LATCH_ADDR: rd_mux = rd_p2;
      port_pkg::CARRIER_PIN_SELECT_ADDR: rd_mux = carrier_select_bits_q;
      port_pkg::PULLUP_DISABLE_ZERO_ADDR: rd_mux = pd0_q;
      port_pkg::PULLUP_DISABLE_ONE_ADDR: rd_mux = pd1_q;
      port_pkg::PULLUP_DISABLE_TWO_ADDR: rd_mux = pd2_q;
      default: rd_mux = port_pkg::READ_ZERO;
    endcase
  end

  // answer one cycle after the request; unmapped addresses read zero
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      SFR_RDATA <= '0;
      SFR_RVALID <= 1'b0;
      PIN_SAMPLED_ZERO <= '1;
    end else begin
      SFR_RVALID <= rd;
      if (rd) SFR_RDATA <= rd_mux;
      PIN_SAMPLED_ZERO <= pin_lvl_q[7:0];
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_latch_read;
    rd && SFR_REQ.rmw && SFR_REQ.addr == port_pkg::PORT_ZERO_LATCH_ADDR;
  endsequence

  sequence s_pin_read;
    rd && !SFR_REQ.rmw && SFR_REQ.addr == port_pkg::PORT_ONE_LATCH_ADDR;
  endsequence

  a_latch_write: assert property (@(posedge CLK) disable iff (!rst_n)
    wr_p0 |=> latch0_q == $past(SFR_REQ.wdata))
    else $error("latch did not capture bus data");

  a_latch_read: assert property (@(posedge CLK) disable iff (!rst_n)
    s_latch_read |=> SFR_RVALID && SFR_RDATA == $past(latch0_q))
    else $error("latch read returned wrong data");

  a_pin_read: assert property (@(posedge CLK) disable iff (!rst_n)
    s_pin_read |=> SFR_RDATA == $past(pin_lvl_q[15:8]))
    else $error("pin read returned wrong data");

  a_open_drain: assert property (@(posedge CLK) disable iff (!rst_n)
    ##1 (PIN_OUT_ZERO == 8'h00 && PIN_OUT_ONE == 8'h00))
    else $error("pin driven high");

  a_low_drive: assert property (@(posedge CLK) disable iff (!rst_n)
    (PERIPH_OWN_ONE[2] == 1'b0 && latch1_q[2] == 1'b0) |=> PIN_OE_ONE[2])
    else $error("latch zero not driven low");

  a_float_high: assert property (@(posedge CLK) disable iff (!rst_n)
    (PERIPH_OWN_ONE[0] == 1'b0 && latch1_q[0] && pd1_q[0]) |=> !PIN_OE_ONE[0])
    else $error("open-drain pin not released");

  a_carrier_xor: assert property (@(posedge CLK) disable iff (!rst_n)
    (!PERIPH_OWN_ZERO[3] && carrier_on && sel[0]) |=>
      PIN_OE_ZERO[3] == !($past(latch0_q[3]) ^ $past(wave)))
    else $error("carrier not xored onto pin");

  a_carrier_gate: assert property (@(posedge CLK) disable iff (!rst_n)
    (!PERIPH_OWN_ONE[6] && !carrier_on) |=> PIN_OE_ONE[6] == !$past(latch1_q[6]))
    else $error("carrier leaked while disabled");

  a_pullup_map: assert property (@(posedge CLK) disable iff (!rst_n)
    wr_pd0 |=> ##1 PULLUP_ON_ZERO == ~$past(SFR_REQ.wdata, 2))
    else $error("pull-up map wrong");

  a_periph_owns: assert property (@(posedge CLK) disable iff (!rst_n)
    PERIPH_OWN_TWO[0] |=> PIN_OE_TWO[0] == !$past(PERIPH_OUT_TWO[0]))
    else $error("peripheral did not own pin");

endmodule

// *** pkg/port_pkg.sv ***
// constants and types for the three parallel ports and carrier generator
// assumes the cpu special-function-register bus runs on CLK at 125 MHz
package port_pkg;

  // ----------------------------------------------------------------
  // register offsets on the special-function-register bus
  // ----------------------------------------------------------------
  localparam logic [7:0] PORT_ZERO_LATCH_ADDR = 8'h80;
  localparam logic [7:0] PORT_ONE_LATCH_ADDR = 8'h90;
  localparam logic [7:0] CARRIER_PIN_SELECT_ADDR = 8'h9f;
  localparam logic [7:0] PORT_TWO_LATCH_ADDR = 8'ha0;
  localparam logic [7:0] PULLUP_DISABLE_ZERO_ADDR = 8'hb2;
  localparam logic [7:0] PULLUP_DISABLE_ONE_ADDR = 8'hb3;
  localparam logic [7:0] PULLUP_DISABLE_TWO_ADDR = 8'hb4;

  // ----------------------------------------------------------------
  // reset values and field layouts
  // ----------------------------------------------------------------
  localparam logic [7:0] LATCH_RESET = 8'hff;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] PULLUP_TWO_MASK = 8'h27;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam int RESET_PIN_BIT = 5;

  // ----------------------------------------------------------------
  // carrier timing: half period count derived from the clock rate
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 125000000;
  localparam int CARRIER_HZ = 38000;
  localparam int CARRIER_HALF_CYCLES = CLK_HZ / (2 * CARRIER_HZ);
  localparam int CARRIER_CNT_W = 11;
  localparam logic [CARRIER_CNT_W-1:0] CARRIER_HALF_LAST =
    CARRIER_CNT_W'(CARRIER_HALF_CYCLES - 1);

  // one cpu request on the sfr bus
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic rmw;
  } sfr_req_t;

  // per-port pin drive bundle
  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
  } pin_drive_t;

endpackage

// *** hdl/carrier_gen.sv ***
// divides CLK down to a continuous 50 percent 38 kHz square wave
// assumes the reset it receives is already synchronised to CLK
`timescale 1ns/1ps
module carrier_gen (
  input wire logic clk,
  input wire logic rst_n,
  output logic wave
);

  logic [port_pkg::CARRIER_CNT_W-1:0] cnt_q;
  logic wave_q;
  wire half_done = (cnt_q == port_pkg::CARRIER_HALF_LAST);

  // free-running divider so the wave never stalls between uses
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      wave_q <= 1'b0;
    end else if (half_done) begin
      cnt_q <= '0;
      wave_q <= ~wave_q;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign wave = wave_q;

  a_half_period: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(wave_q) |-> $past(half_done))
    else $error("carrier toggled off its half period");

endmodule

// *** testbench/pin_world.sv ***
// model of the parts wired to one port: weak pull-up, external open-drain drivers
// assumes the design only ever pulls a pin low and reports its pull-up per pin
`timescale 1ns/1ps
module pin_world (
  input wire logic clk,
  input wire logic [7:0] out,
  input wire logic [7:0] oe,
  input wire logic [7:0] pull_on,
  input wire logic [7:0] ext_low,
  output logic [7:0] level
);
  logic [7:0] float_q = 8'h5a;

  // an undriven pin without pull-up wanders, so a stale level never reads as valid
  always @(posedge clk) begin
    float_q <= ~float_q;
  end

  // wired-and: any low driver wins, otherwise the pull-up, otherwise float
  assign level = ~((oe & ~out) | ext_low) & (pull_on | float_q);
endmodule

// *** testbench/tb_top.sv ***
// self-checking bench for the three parallel ports and carrier steering
// assumes port_pkg and parallel_ports are compiled first; CLK runs at 125 MHz
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------------------------------
  // stimulus and wiring
  // ----------------------------------------------------------------
  localparam int HALF = 125000000 / 76000;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  port_pkg::sfr_req_t req = '0;
  logic [7:0] rdata;
  logic rvalid;
  logic gen = 1'b0;
  logic [7:0] own [3] = '{default: 8'h00};
  logic [7:0] pout [3] = '{default: 8'h00};
  logic [7:0] ext [3] = '{default: 8'h00};
  logic [7:0] pin [3];
  logic [7:0] o [3];
  logic [7:0] oe [3];
  logic [7:0] pu [3];
  logic [7:0] samp0;
  logic [7:0] ladr [3] = '{8'h80, 8'h90, 8'ha0};
  logic [7:0] padr [3] = '{8'hb2, 8'hb3, 8'hb4};
  int seed = 95617;
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;

  initial forever #4 CLK = ~CLK;

  parallel_ports dut (.CLK(CLK), .RST_N(RST_N), .SFR_REQ(req), .SFR_RDATA(rdata),
    .SFR_RVALID(rvalid), .CARRIER_GLOBAL_ENABLE(gen), .PERIPH_OWN_ZERO(own[0]),
    .PERIPH_OWN_ONE(own[1]), .PERIPH_OWN_TWO(own[2]), .PERIPH_OUT_ZERO(pout[0]),
    .PERIPH_OUT_ONE(pout[1]), .PERIPH_OUT_TWO(pout[2]), .PIN_IN_ZERO(pin[0]),
    .PIN_IN_ONE(pin[1]), .PIN_IN_TWO(pin[2]), .PIN_OUT_ZERO(o[0]), .PIN_OE_ZERO(oe[0]),
    .PIN_OUT_ONE(o[1]), .PIN_OE_ONE(oe[1]), .PIN_OUT_TWO(o[2]), .PIN_OE_TWO(oe[2]),
    .PULLUP_ON_ZERO(pu[0]), .PULLUP_ON_ONE(pu[1]), .PULLUP_ON_TWO(pu[2]),
    .PIN_SAMPLED_ZERO(samp0));

  for (genvar g = 0; g < 3; g++) begin : w
    pin_world u (.clk(CLK), .out(o[g]), .oe(oe[g]), .pull_on(pu[g]), .ext_low(ext[g]),
      .level(pin[g]));
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // a hang is cut short well beyond the ~31k cycles the tests need
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 60000) begin
      fails++;
      give_verdict();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0, rmw: 1'b0};
    @(posedge CLK);
    req.wr <= 1'b0;
  endtask

  // valid is due exactly one cycle after the read strobe is taken
  task automatic rd(input logic [7:0] a, input logic m, output logic [7:0] d);
    @(posedge CLK);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1, rmw: m};
    @(posedge CLK);
    req.rd <= 1'b0;
    #1;
    check("read valid", {15'h0, rvalid}, 16'h1);
    d = rdata;
  endtask

  // carrier pin map: high byte port 1, low byte port 0
  function automatic logic [15:0] mod_mask(input logic [7:0] sel);
    logic [15:0] m;
    m = '0;
    m[14] = sel[7];
    m[13] = sel[6];
    m[12] = sel[5];
    m[9] = sel[4];
    m[2] = sel[3];
    m[7] = sel[2];
    m[5] = sel[1];
    m[3] = sel[0];
    return m;
  endfunction

  // collects which drive enables toggle, and the gap between two toggles
  task automatic watch(output logic [15:0] chg, output int half);
    logic [15:0] prev;
    int t1;
    chg = '0;
    half = 0;
    t1 = -1;
    #1;
    prev = {oe[1], oe[0]};
    for (int c = 0; c < 3400; c++) begin
      @(posedge CLK);
      #1;
      if ({oe[1], oe[0]} !== prev) begin
        if (t1 >= 0 && half == 0) half = c - t1;
        if (t1 < 0) t1 = c;
        chg |= {oe[1], oe[0]} ^ prev;
        prev = {oe[1], oe[0]};
      end
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] d;
    logic [7:0] v;
    logic [7:0] e;
    logic [7:0] m;
    logic [15:0] chg;
    int half;
    int p;
    repeat (10) @(posedge CLK);
    RST_N <= 1'b1;
    repeat (3) @(posedge CLK);
    #1;
    check("pullups after reset", {pu[0], pu[1]}, 16'hffff);
    check("port2 pullups after reset", pu[2], 16'h27);
    for (int i = 0; i < 3; i++) begin
      rd(padr[i], 1'b0, d);
      check("pullup reg reset", d, 16'h0);
      rd(ladr[i], 1'b1, d);
      check("latch reset", d, 16'hff);
    end
    rd(8'h9f, 1'b0, d);
    check("carrier select reset", d, 16'h0);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      p = (i < 3) ? i : int'($unsigned($random(seed)) % 3);
      // port 2 only has pins 0-2 and the reset pin behind a pull-up
      m = (p == 2) ? 8'h27 : 8'hff;
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
      e = 8'($random(seed));
      ext[p] <= e;
      wr(ladr[p], v);
      repeat (8) @(posedge CLK);
      rd(ladr[p], 1'b1, d);
      check("latch read", d, v);
      rd(ladr[p], 1'b0, d);
      check("pin read", d & m, v & ~e & m);
      if (p == 0) check("sampled pins", samp0, v & ~e);
      check("drive low", oe[p], {8'h00, ~v & m});
      check("never drive high", o[p], 16'h0);
    end
    $display("test latch and pins done");
    for (int i = 0; i < 3; i++) begin
      v = 8'($random(seed)) & ((i == 2) ? 8'h27 : 8'hff);
      wr(padr[i], v);
      rd(padr[i], 1'b0, d);
      check("pullup reg", d, v);
      check("pullup out", pu[i], ~v & ((i == 2) ? 8'h27 : 8'hff));
    end
    e = 8'($random(seed));
    ext[0] <= e;
    wr(8'hb2, 8'hff);
    wr(8'h80, 8'hff);
    repeat (8) @(posedge CLK);
    rd(8'h80, 1'b0, d);
    check("open drain input", d & e, 16'h0);
    check("open drain released", oe[0], 16'h0);
    wr(8'hb2, 8'h00);
    wr(8'h81, 8'h00);
    rd(8'h81, 1'b0, d);
    check("unmapped read", d, 16'h0);
    rd(8'h80, 1'b1, d);
    check("unmapped write ignored", d, 16'hff);
    $display("test pullups done");
    for (int i = 0; i < 4; i++) begin
      p = i & 1;
      v = 8'($random(seed));
      own[p] <= 8'($random(seed));
      pout[p] <= 8'($random(seed));
      wr(ladr[p], v);
      repeat (3) @(posedge CLK);
      #1;
      e = (own[p] & ~pout[p]) | (~own[p] & ~v);
      check("peripheral takeover", oe[p], {8'h00, e});
      own[p] <= 8'h00;
    end
    $display("test peripheral done");
    ext[0] <= 8'h00;
    ext[1] <= 8'h00;
    wr(8'h80, 8'h00);
    wr(8'h90, 8'h00);
    gen <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      wr(8'h9f, 8'h01 << i);
      repeat (4) @(posedge CLK);
      watch(chg, half);
      check("carrier pin map", chg, mod_mask(8'h01 << i));
      check("carrier half period", 16'(half), 16'(HALF));
    end
    wr(8'h9f, 8'hff);
    gen <= 1'b0;
    repeat (6) @(posedge CLK);
    watch(chg, half);
    check("global enable off", chg, 16'h0);
    $display("test carrier done");
    give_verdict();
  end
endmodule
